// >>> logic/fls_pkg.sv
// Shared constants and types of the fuel sensor serial command interpreter
package fls_pkg;

	// ---------------------------------------------------------------
	// Frame bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] PFX_QUERY = 8'h31; // Prefix of a query frame
	localparam logic [7:0] PFX_RESP = 8'h3E; // Prefix of a response frame
	localparam logic [7:0] OP_READ = 8'h06; // One-shot binary read
	localparam logic [7:0] OP_CONT = 8'h07; // binary_periodic_cmd
	localparam logic [7:0] ADDR_BCAST = 8'hFF; // Broadcast network address
	localparam logic [7:0] ACK_OK = 8'h00; // Status byte of the periodic acknowledge
	localparam logic [7:0] CRC_INIT = 8'h00; // Hash start value
	localparam logic [7:0] CRC_FOLD = 8'h18; // Feedback taps, shifted form
	localparam logic [7:0] CRC_TOP = 8'h80; // Bit set after a feedback shift

	// ---------------------------------------------------------------
	// Symbolic characters
	// ---------------------------------------------------------------
	localparam logic [7:0] CH_D = 8'h44; // First character of both text commands
	localparam logic [7:0] CH_O = 8'h4F; // Second character, one-shot read
	localparam logic [7:0] CH_P = 8'h50; // Second character, text_periodic_cmd
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_T = 8'h74;
	localparam logic [7:0] CH_N = 8'h4E;
	localparam logic [7:0] CH_EQ = 8'h3D;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ALPHA = 8'h37; // 'A' minus ten
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;

	// ---------------------------------------------------------------
	// Frame lengths (index of the last byte) and timing
	// ---------------------------------------------------------------
	localparam logic [4:0] LAST_TEXT = 5'h15; // 22 characters
	localparam logic [4:0] LAST_DATA = 5'h08; // 9 bytes
	localparam logic [4:0] LAST_ACK = 5'h04; // 5 bytes
	localparam int CLK_HZ = 200_000_000; // ref_clk rate
	localparam int SEC_S = 1; // Base tick, seconds
	localparam int CYC_PER_SEC = CLK_HZ * SEC_S; // Cycles per base tick
	localparam logic [6:0] EXP_WIN_S = 7'h05; // Exponential averaging interval, s
	localparam logic [6:0] MAX_WIN_S = 7'h5A; // Longest moving window, 90 s

	// Auto-output setting codes
	localparam logic [1:0] AUTO_OFF = 2'h0;
	localparam logic [1:0] AUTO_BIN = 2'h1;
	localparam logic [1:0] AUTO_TEXT = 2'h2;

	typedef enum logic [2:0] {RX_IDLE, RX_ADDR, RX_OP, RX_HASH, RX_TXT} fls_rx_t;
	typedef enum logic [1:0] {K_TEXT, K_DATA, K_ACK} fls_kind_t;
	typedef enum logic [1:0] {PER_OFF, PER_BIN, PER_TEXT} fls_per_t;

endpackage

// >>> logic/fls_crc_step.sv
// One byte step of the frame hash, bit-serial form unrolled
module fls_crc_step
	import fls_pkg::*;
(
	input wire logic [7:0] crc_in,
	input wire logic [7:0] data_in,
	output logic [7:0] crc_out
);

	// ---------------------------------------------------------------
	// Hash update, least significant data bit first
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [7:0] c;
		logic [7:0] d;
		c = crc_in;
		d = data_in;
		for (int i = 0; i < 8; i++)
		begin
			// Data bit unlike hash bit zero: fold in taps, shift, set top
			if (d[0] ^ c[0])
				c = ((c ^ CRC_FOLD) >> 1) | CRC_TOP; // RULE12
			else
				c = c >> 1; // RULE12
			d = d >> 1;
		end
		crc_out = c;
	end

endmodule

// >>> logic/fls_cmd.sv
// Serial command interpreter: text and binary readout of a fuel level sensor
// Overview of operation
// RULE1: Accept binary frames and ASCII commands alike
// RULE2: Text read answers one labelled line, CRLF
// RULE3: Text numbers are hexadecimal ASCII digits
// RULE4: Report raw frequency, temperature, level
// RULE5: Text periodic command repeats line each interval
// RULE6: Zero interval means no periodic output
// RULE7: Valid command suspends periodic text output
// RULE8: Text read or new settings stop text
// RULE9: Query prefix 31h, response prefix 3Eh
// RULE10: Address, opcode 06h/07h, zero to eight options; the parser takes no option bytes, the hash follows the opcode
// RULE11: Last byte is hash over all
// RULE12: Hash steps LSB first with 18h feedback
// RULE13: Binary read answer: temperature, level, frequency, hash
// RULE14: Multi-byte values go low byte first
// RULE15: Level clipped to configurable maximum
// RULE16: Exponential averaging over fixed five seconds
// RULE17: Moving average window zero to ninety seconds
// RULE18: Network mode answers own or broadcast address
// RULE19: Binary periodic command repeats data frames
// RULE20: Auto-output setting picks none, binary, text
// RULE21: Bad prefix or hash frames are dropped
// RULE22: Unknown text input leaves periodic state alone
module fls_cmd
	import fls_pkg::*;
#(
	parameter int CYC_PER_S = CYC_PER_SEC // Cycles per second, shorten in simulation
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] rx_data, // Received byte from the UART
	input wire logic rx_valid, // One-cycle strobe with rx_data
	output logic [7:0] tx_data, // Byte for the UART
	output logic tx_valid, // Held until tx_ready
	input wire logic tx_ready, // UART takes tx_data
	input wire logic [15:0] meas_freq, // Instantaneous generator frequency
	input wire logic [7:0] meas_temp, // Temperature or error code
	input wire logic [15:0] meas_level, // Level or volume value
	input wire logic [1:0] auto_mode, // Periodic output at power-up
	input wire logic [15:0] out_period_s, // Periodic output interval, s
	input wire logic net_mode, // High: answer own or broadcast only
	input wire logic [7:0] own_addr, // Network address
	input wire logic [15:0] max_level, // Ceiling of the reported level
	input wire logic avg_moving, // High: moving average, low: exponential
	input wire logic [6:0] avg_window_s, // Moving window, s
	input wire logic cfg_changed, // One-cycle strobe on new settings
	output logic [1:0] periodic_state // 0 off, 1 binary, 2 text
);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (CYC_PER_S < 2)
		$error("CYC_PER_S must be at least 2");

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		fls_rx_t rx_st; // Receive parser state
		logic [7:0] rx_addr; // Address of the frame in progress
		logic [7:0] rx_op; // Opcode of the frame in progress
		logic [7:0] rx_crc; // Running hash of the received frame
		logic cmd_pend; // Answer waiting for the transmitter
		fls_kind_t cmd_kind;
		logic [7:0] cmd_addr;
		logic [7:0] cmd_op;
		logic per_pend; // Periodic frame waiting
		fls_per_t per_mode; // Periodic output mode
		logic boot; // First cycle after reset: load auto setting
		logic [31:0] sec_cnt; // Cycles within the current second
		logic [15:0] per_cnt; // Seconds since the last periodic frame
		logic [15:0] lvl_avg; // Averaged level
		logic busy; // Frame being sent
		fls_kind_t kind;
		logic [4:0] idx; // Index of the byte on tx_data
		logic [7:0] addr; // Address and opcode echoed in the frame
		logic [7:0] op;
		logic [7:0] crc; // Hash of bytes already accepted by the UART
		logic [7:0] sn_t; // Snapshot of the values being sent
		logic [15:0] sn_n;
		logic [15:0] sn_f;
		logic [7:0] tx_data;
		logic tx_valid;
	} fls_state_t;

	fls_state_t st;
	fls_state_t next_st;
	logic [7:0] rx_crc_next; // Hash including the received byte
	logic [7:0] tx_crc_next; // Hash including the byte now accepted

	// Every frame's hash starts from zero, whatever a text command or bad frame left behind
	fls_crc_step u_rx_crc
	(
		.crc_in((st.rx_st == RX_IDLE) ? CRC_INIT : st.rx_crc), // RULE11
		.data_in(rx_data),
		.crc_out(rx_crc_next)
	);

	fls_crc_step u_tx_crc
	(
		.crc_in(st.crc),
		.data_in(st.tx_data),
		.crc_out(tx_crc_next)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// One hex digit as an ASCII character
	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_ALPHA + {4'h0, n}); // RULE3
	endfunction

	// Byte at position i of a frame; h is the hash after the preceding bytes
	function automatic logic [7:0] frame_byte(input fls_kind_t k, input logic [4:0] i,
		input logic [7:0] a, input logic [7:0] o, input logic [7:0] t,
		input logic [15:0] n, input logic [15:0] f, input logic [7:0] h);
		frame_byte = h;
		if (k == K_TEXT)
		begin
			// F=ffff t=tt N=nnnn.0 CR LF, most significant digit first
			case (i)
				5'h00: frame_byte = CH_F; // RULE2
				5'h01, 5'h08, 5'h0D: frame_byte = CH_EQ;
				5'h02: frame_byte = hex_ch(f[15:12]); // RULE4
				5'h03: frame_byte = hex_ch(f[11:8]);
				5'h04: frame_byte = hex_ch(f[7:4]);
				5'h05: frame_byte = hex_ch(f[3:0]);
				5'h06, 5'h0B: frame_byte = CH_SP;
				5'h07: frame_byte = CH_T;
				5'h09: frame_byte = hex_ch(t[7:4]);
				5'h0A: frame_byte = hex_ch(t[3:0]);
				5'h0C: frame_byte = CH_N;
				5'h0E: frame_byte = hex_ch(n[15:12]);
				5'h0F: frame_byte = hex_ch(n[11:8]);
				5'h10: frame_byte = hex_ch(n[7:4]);
				5'h11: frame_byte = hex_ch(n[3:0]);
				5'h12: frame_byte = CH_DOT;
				5'h13: frame_byte = CH_ZERO;
				5'h14: frame_byte = CH_CR; // RULE2
				default: frame_byte = CH_LF;
			endcase
		end
		else
		begin
			// Prefix, address, opcode, body, hash; body values low byte first
			case (i)
				5'h00: frame_byte = PFX_RESP; // RULE9
				5'h01: frame_byte = a;
				5'h02: frame_byte = o;
				5'h03: frame_byte = (k == K_ACK) ? ACK_OK : t; // RULE13
				5'h04: frame_byte = (k == K_ACK) ? h : n[7:0]; // RULE14 RULE11
				5'h05: frame_byte = n[15:8];
				5'h06: frame_byte = f[7:0]; // RULE14
				5'h07: frame_byte = f[15:8];
				default: frame_byte = h; // RULE11
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [6:0] div;
		logic [15:0] lvl_rep;
		logic [4:0] last;
		logic sec_tick;
		logic cmd_new; // Answer queued by the parser this cycle
		logic per_new; // Periodic tick this cycle
		next_st = st;
		cmd_new = 1'b0;
		per_new = 1'b0;
		last = (st.kind == K_TEXT) ? LAST_TEXT : (st.kind == K_ACK) ? LAST_ACK : LAST_DATA;
		sec_tick = (st.sec_cnt == 32'(CYC_PER_S - 1));
		// Clip to the configured ceiling
		lvl_rep = (st.lvl_avg > max_level) ? max_level : st.lvl_avg; // RULE15
		// Averaging divisor: fixed for exponential, window for moving
		div = avg_moving ? avg_window_s : EXP_WIN_S; // RULE16 RULE17
		if (div > MAX_WIN_S)
			div = MAX_WIN_S; // RULE17

		// Auto-output setting takes effect once after reset
		next_st.boot = 1'b0;
		if (st.boot)
		begin
			case (auto_mode) // RULE20
				AUTO_BIN: next_st.per_mode = PER_BIN;
				AUTO_TEXT: next_st.per_mode = PER_TEXT;
				default: next_st.per_mode = PER_OFF;
			endcase
		end

		// Second divider and averaging filter, one step per second
		next_st.sec_cnt = sec_tick ? 32'h0 : st.sec_cnt + 32'h1;
		if (sec_tick)
		begin
			// First-order filter; a window of 0 or 1 passes the raw value
			if (div <= 7'h01)
				next_st.lvl_avg = meas_level;
			else if (meas_level >= st.lvl_avg)
				next_st.lvl_avg = st.lvl_avg + (meas_level - st.lvl_avg) / {9'h0, div}; // RULE16
			else
				next_st.lvl_avg = st.lvl_avg - (st.lvl_avg - meas_level) / {9'h0, div}; // RULE17
			// Periodic timer; a zero interval never fires
			if (st.per_mode == PER_OFF || out_period_s == 16'h0)
				next_st.per_cnt = 16'h0; // RULE6
			else if (st.per_cnt + 16'h1 >= out_period_s)
			begin
				next_st.per_cnt = 16'h0;
				next_st.per_pend = 1'b1; // RULE5 RULE19
				per_new = 1'b1;
			end
			else
				next_st.per_cnt = st.per_cnt + 16'h1;
		end

		// New settings stop text output
		if (cfg_changed && st.per_mode == PER_TEXT)
			next_st.per_mode = PER_OFF; // RULE8

		// Receive parser: binary frames and two-character text commands
		if (rx_valid)
		begin
			next_st.rx_crc = rx_crc_next; // RULE11
			case (st.rx_st)
				RX_ADDR:
				begin
					next_st.rx_addr = rx_data;
					next_st.rx_st = RX_OP; // RULE10
				end
				RX_OP:
				begin
					next_st.rx_op = rx_data;
					// Both known opcodes carry no option bytes
					next_st.rx_st = (rx_data == OP_READ || rx_data == OP_CONT) ? RX_HASH : RX_IDLE;
				end
				RX_HASH:
				begin
					next_st.rx_st = RX_IDLE;
					// Hash must match, and in network mode the address too, otherwise drop silently
					if (rx_data == st.rx_crc && (!net_mode || st.rx_addr == own_addr
						|| st.rx_addr == ADDR_BCAST)) // RULE21 RULE18
					begin
						next_st.cmd_pend = 1'b1;
						cmd_new = 1'b1;
						next_st.cmd_addr = st.rx_addr;
						next_st.cmd_op = st.rx_op;
						if (st.rx_op == OP_CONT)
						begin
							next_st.cmd_kind = K_ACK;
							next_st.per_mode = PER_BIN; // RULE19
							next_st.per_cnt = 16'h0;
						end
						else
						begin
							next_st.cmd_kind = K_DATA; // RULE13
							if (st.per_mode == PER_TEXT)
								next_st.per_mode = PER_OFF; // RULE7
						end
					end
				end
				RX_TXT:
				begin
					next_st.rx_st = RX_IDLE;
					if (rx_data == CH_O)
					begin
						next_st.cmd_pend = 1'b1;
						cmd_new = 1'b1;
						next_st.cmd_kind = K_TEXT; // RULE2
						if (st.per_mode == PER_TEXT)
							next_st.per_mode = PER_OFF; // RULE8 RULE7
					end
					else if (rx_data == CH_P)
					begin
						next_st.per_mode = PER_TEXT; // RULE5
						next_st.per_cnt = 16'h0;
					end
					// Anything else is ignored, periodic state kept
				end
				default:
				begin
					// Frame start: either form on the same link
					next_st.rx_crc = rx_crc_next;
					if (rx_data == PFX_QUERY)
						next_st.rx_st = RX_ADDR; // RULE1 RULE9
					else if (rx_data == CH_D)
						next_st.rx_st = RX_TXT; // RULE1
					else
						next_st.rx_st = RX_IDLE; // RULE21 RULE22
					if (rx_data != PFX_QUERY)
						next_st.rx_crc = CRC_INIT;
				end
			endcase
		end

		// Transmitter: command answers take precedence over periodic frames
		if (!st.busy && (st.cmd_pend || (st.per_pend && st.per_mode != PER_OFF)))
		begin
			next_st.busy = 1'b1;
			next_st.idx = 5'h0;
			next_st.crc = CRC_INIT;
			next_st.sn_t = meas_temp; // RULE4
			next_st.sn_n = lvl_rep;
			next_st.sn_f = meas_freq; // RULE4
			if (st.cmd_pend)
			begin
				next_st.cmd_pend = cmd_new; // A request arriving now is kept, set wins
				next_st.kind = st.cmd_kind;
				next_st.addr = st.cmd_addr;
				next_st.op = st.cmd_op;
			end
			else
			begin
				next_st.per_pend = per_new;
				next_st.kind = (st.per_mode == PER_TEXT) ? K_TEXT : K_DATA;
				next_st.addr = own_addr;
				next_st.op = OP_CONT;
			end
			next_st.tx_valid = 1'b1;
			next_st.tx_data = frame_byte(next_st.kind, 5'h0, next_st.addr, next_st.op,
				meas_temp, lvl_rep, meas_freq, CRC_INIT);
		end
		else if (st.busy && tx_ready)
		begin
			// Byte taken: fold it into the hash and present the next one
			next_st.crc = tx_crc_next; // RULE11
			if (st.idx == last)
			begin
				next_st.busy = 1'b0;
				next_st.tx_valid = 1'b0;
			end
			else
			begin
				next_st.idx = st.idx + 5'h1;
				next_st.tx_data = frame_byte(st.kind, st.idx + 5'h1, st.addr, st.op,
					st.sn_t, st.sn_n, st.sn_f, tx_crc_next);
			end
		end
		// A periodic tick with output off is dropped
		if (st.per_mode == PER_OFF)
			next_st.per_pend = 1'b0;
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			st <= '0;
			st.boot <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign tx_data = st.tx_data;
	assign tx_valid = st.tx_valid;
	assign periodic_state = st.per_mode;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_resp_prefix: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE9
		st.tx_valid && st.idx == 5'h0 && st.kind != K_TEXT |-> st.tx_data == PFX_RESP)
		else $error("binary response without response prefix");
	a_text_line_end: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE2
		st.tx_valid && st.kind == K_TEXT && st.idx == LAST_TEXT && $past(st.idx) != LAST_TEXT
		|-> st.tx_data == CH_LF && $past(st.tx_data) == CH_CR)
		else $error("text line does not end in CR LF");
	a_hash_last: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE11
		st.tx_valid && st.kind == K_DATA && st.idx == LAST_DATA |-> st.tx_data == st.crc)
		else $error("final byte differs from running hash");
	a_level_low_first: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE14
		st.tx_valid && st.kind == K_DATA && st.idx == 5'h4 |-> st.tx_data == st.sn_n[7:0])
		else $error("level low byte not sent first");
	a_level_clip: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE15
		!st.busy ##1 st.busy && st.idx == 5'h0 |-> st.sn_n <= $past(max_level))
		else $error("reported level above ceiling");
	a_zero_period: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE6
		$rose(st.per_pend) |-> $past(out_period_s) != 16'h0)
		else $error("periodic frame requested with zero interval");
	a_read_stops: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE8
		rx_valid && st.rx_st == RX_TXT && rx_data == CH_O |=> st.per_mode != PER_TEXT)
		else $error("text read did not stop text output");
	a_net_filter: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE18
		rx_valid && st.rx_st == RX_HASH && net_mode && st.rx_addr != own_addr
		&& st.rx_addr != ADDR_BCAST && !st.cmd_pend |=> !st.cmd_pend)
		else $error("foreign address answered in network mode");
	a_bad_hash: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE21
		rx_valid && st.rx_st == RX_HASH && rx_data != st.rx_crc && !st.cmd_pend
		|=> !st.cmd_pend)
		else $error("frame with bad hash accepted");
	a_tx_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE10
		st.tx_valid && !tx_ready |=> st.tx_valid && $stable(st.tx_data))
		else $error("byte changed before it was taken");

endmodule

// >>> dv/fls_term.sv
// Terminal-side model of the serial link: sends query bytes, takes reply bytes
module fls_term
(
	input wire logic ref_clk,
	input wire logic slow, // High: tx_ready low every other cycle
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got[$]; // Reply bytes in arrival order
	logic phase; // Stall toggle

	initial
	begin
		rx_data = 8'hA5;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		phase = 1'b0;
	end

	// Take a byte at each edge where the handshake completes
	always @(posedge ref_clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
		phase <= ~phase;
		tx_ready <= #1 ~slow | phase;
	end

	// Back-to-back bytes; the line shows the inverse once released, not a stale byte
	task automatic send(input logic [7:0] q[$]);
		foreach (q[k])
		begin
			@(posedge ref_clk);
			#1;
			rx_data = q[k];
			rx_valid = 1'b1;
		end
		@(posedge ref_clk);
		#1;
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench of the serial command interpreter against a queue model
module tb
	import fls_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CPS = 100; // Short second keeps periodic runs brief
	logic ref_clk, reset_n, rx_valid, tx_valid, tx_ready, net_mode, cfg_changed, slow;
	logic [7:0] rx_data, tx_data, meas_temp, own_addr;
	logic [15:0] meas_freq, meas_level, out_period_s, max_level;
	logic [1:0] auto_mode, periodic_state;
	logic avg_moving;
	logic [6:0] avg_window_s;
	logic [31:0] lfsr = 32'hE6B4CDFB; // Fixed seed
	logic [31:0] r;
	logic [7:0] exp[$]; // Expected reply bytes
	int bad_count, n_tests, div_exp;

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	fls_term i_fls_term (.ref_clk(ref_clk), .slow(slow), .rx_data(rx_data),
		.rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	// Filter settings come from the bench; pass-through until the filter scenario
	fls_cmd #(.CYC_PER_S(CPS)) i_fls_cmd (.ref_clk(ref_clk), .reset_n(reset_n),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .meas_freq(meas_freq), .meas_temp(meas_temp),
		.meas_level(meas_level), .auto_mode(auto_mode), .out_period_s(out_period_s),
		.net_mode(net_mode), .own_addr(own_addr), .max_level(max_level),
		.avg_moving(avg_moving), .avg_window_s(avg_window_s), .cfg_changed(cfg_changed),
		.periodic_state(periodic_state));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction

	// Bit-serial hash, low bit first
	function automatic logic [7:0] crc8(input logic [7:0] q[$]);
		logic [7:0] c;
		logic [7:0] b;
		c = 8'h00;
		foreach (q[k])
		begin
			b = q[k];
			for (int i = 0; i < 8; i++)
			begin
				c = ((b[0] ^ c[0]) == 1'b1) ? ((c ^ 8'h18) >> 1) | 8'h80 : c >> 1;
				b = b >> 1;
			end
		end
		return c;
	endfunction

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask

	// All drives land one time unit after the edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic reset_dut(input logic [1:0] mode);
		auto_mode = mode;
		reset_n = 1'b0;
		step(8);
		reset_n = 1'b1;
		i_fls_term.got.delete();
	endtask

	task automatic send_text(input logic [7:0] c);
		logic [7:0] q[$];
		q = {CH_D, c};
		i_fls_term.send(q);
	endtask

	task automatic query(input logic [7:0] pfx, input logic [7:0] a, input logic [7:0] op,
		input logic [7:0] flip);
		logic [7:0] q[$];
		q = {pfx, a, op};
		q.push_back(crc8(q) ^ flip);
		i_fls_term.send(q);
	endtask

	// One filter step from zero, or the raw level when div_exp is 1
	function automatic logic [15:0] lvl();
		int v;
		v = meas_level / div_exp;
		return (v > max_level) ? max_level : 16'(v);
	endfunction

	task automatic exp_text();
		logic [15:0] n;
		n = lvl();
		exp = {CH_F, CH_EQ, hx(meas_freq[15:12]), hx(meas_freq[11:8]), hx(meas_freq[7:4]),
			hx(meas_freq[3:0]), CH_SP, CH_T, CH_EQ, hx(meas_temp[7:4]), hx(meas_temp[3:0]),
			CH_SP, CH_N, CH_EQ, hx(n[15:12]), hx(n[11:8]), hx(n[7:4]), hx(n[3:0]),
			CH_DOT, CH_ZERO, CH_CR, CH_LF};
	endtask

	task automatic exp_data(input logic [7:0] a, input logic [7:0] op);
		logic [15:0] n;
		n = lvl();
		exp = {PFX_RESP, a, op, meas_temp, n[7:0], n[15:8]};
		exp.push_back(meas_freq[7:0]);
		exp.push_back(meas_freq[15:8]);
		exp.push_back(crc8(exp));
	endtask

	// Bounded wait for the whole frame, then byte-by-byte compare
	task automatic expect_frame(input string what);
		int k;
		k = 0;
		while (i_fls_term.got.size() < exp.size() && k < 600)
		begin
			step(1);
			k++;
		end
		if (i_fls_term.got.size() < exp.size())
		begin
			cmp({what, " length"}, 16'(exp.size()), 16'(i_fls_term.got.size()));
			tally_and_finish();
		end
		foreach (exp[i])
			cmp(what, 16'(exp[i]), 16'(i_fls_term.got.pop_front()));
	endtask

	task automatic quiet(input string what, input int n);
		step(n);
		cmp(what, 16'h0000, 16'(i_fls_term.got.size()));
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		bad_count = 0;
		n_tests = 0;
		{net_mode, cfg_changed, slow} = '0;
		avg_moving = 1'b1; // Moving window of 0 passes the raw level
		avg_window_s = 7'h00;
		div_exp = 1;
		{meas_freq, meas_level, meas_temp, own_addr} = '0;
		max_level = 16'hFFFF;
		out_period_s = 16'h0000;
		reset_dut(AUTO_OFF);
		step(2);
		cmp("state after reset", 16'(AUTO_OFF), 16'(periodic_state));
		// Random readings through both read forms, any address when stand-alone
		for (int t = 0; t < 8; t++)
		begin
			r = rnd();
			{meas_freq, meas_level} = r;
			r = rnd();
			meas_temp = r[7:0];
			slow = r[8];
			max_level = r[9] ? 16'hFFFF : r[31:16];
			step(CPS + 1); // The level only moves on a one-second tick
			send_text(CH_O);
			exp_text();
			expect_frame("text line");
			query(PFX_QUERY, r[15:8], OP_READ, 8'h00);
			exp_data(r[15:8], OP_READ);
			expect_frame("read frame");
		end
		net_mode = 1'b1;
		own_addr = 8'h42;
		query(PFX_QUERY, 8'h42, OP_READ, 8'h00);
		exp_data(8'h42, OP_READ);
		expect_frame("own address");
		query(PFX_QUERY, ADDR_BCAST, OP_READ, 8'h00);
		exp_data(ADDR_BCAST, OP_READ);
		expect_frame("broadcast");
		query(PFX_QUERY, 8'h43, OP_READ, 8'h00);
		quiet("foreign address", 60);
		query(PFX_QUERY, 8'h42, OP_READ, 8'h01);
		quiet("bad hash", 60);
		query(PFX_RESP, 8'h42, OP_READ, 8'h00);
		quiet("bad prefix", 60);
		send_text(8'h58);
		quiet("unknown text", 60);
		// Periodic text with zero interval stays silent
		send_text(CH_P);
		quiet("zero interval", 400);
		send_text(CH_O);
		exp_text();
		expect_frame("read stops text");
		cmp("state after read", 16'(PER_OFF), 16'(periodic_state));
		out_period_s = 16'h0001;
		send_text(CH_P);
		exp_text();
		expect_frame("periodic line");
		expect_frame("periodic again");
		send_text(8'h58);
		cmp("state after junk", 16'(PER_TEXT), 16'(periodic_state));
		cfg_changed = 1'b1;
		step(1);
		cfg_changed = 1'b0;
		step(60);
		i_fls_term.got.delete();
		cmp("state after settings", 16'(PER_OFF), 16'(periodic_state));
		quiet("settings stop text", 300);
		send_text(CH_P);
		expect_frame("line before read");
		query(PFX_QUERY, 8'h42, OP_READ, 8'h00);
		exp_data(8'h42, OP_READ);
		expect_frame("read during text");
		quiet("read stops text", 300);
		// Binary periodic: acknowledge, then frames from own address
		exp = {PFX_RESP, ADDR_BCAST, OP_CONT, ACK_OK};
		exp.push_back(crc8(exp));
		query(PFX_QUERY, ADDR_BCAST, OP_CONT, 8'h00);
		expect_frame("periodic ack");
		cmp("state binary", 16'(PER_BIN), 16'(periodic_state));
		exp_data(own_addr, OP_CONT);
		expect_frame("periodic data");
		expect_frame("periodic data again");
		// Auto output chosen at power-up
		reset_dut(AUTO_TEXT);
		step(2);
		cmp("auto text", 16'(PER_TEXT), 16'(periodic_state));
		exp_text();
		expect_frame("auto line");
		reset_dut(AUTO_BIN);
		step(2);
		cmp("auto binary", 16'(PER_BIN), 16'(periodic_state));
		exp_data(own_addr, OP_CONT);
		expect_frame("auto frame");
		// Filter from reset: exactly one tick has moved the level a fraction of the way
		avg_window_s = 7'h7F;
		for (int v = 0; v < 2; v++)
		begin
			avg_moving = (v == 1);
			div_exp = (v == 0) ? int'(EXP_WIN_S) : int'(MAX_WIN_S);
			reset_dut(AUTO_OFF);
			step(CPS + 50);
			send_text(CH_O);
			exp_text();
			expect_frame("filtered level");
		end
		tally_and_finish();
	end
endmodule
